// File: hw/interrupt_priority_select.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Bit 7 is unused; reads return one, writes are ignored.
// R2: Bit 6 sets SPI interrupt priority; one high, zero low.
// R3: Bit 5 sets timer 2 interrupt priority; one high, zero low.
// R4: Bit 4 sets UART0 interrupt priority; one high, zero low.
// R5: Bit 3 sets timer 1 interrupt priority; one high, zero low.
// R6: Bit 2 sets external interrupt 1 priority; one high, zero low.
// R7: Bit 1 sets timer 0 interrupt priority; one high, zero low.
// R8: Bit 0 sets external interrupt 0 priority; one high, zero low.
// R9: Bits 6 to 0 are read/write and hold until next write or reset.
// R10: High requests preempt low service; low never preempts high.
// R11: Reset clears all priority bits, so every source starts low.
module interrupt_priority_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [irq_prio_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [irq_prio_pkg::DATA_W-1:0] avs_writedata,
  output logic [irq_prio_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt sources and core handshake
  input wire logic [irq_prio_pkg::NSRC-1:0] irq_req,
  input wire logic svc_done,
  output logic svc_take,
  output logic [irq_prio_pkg::SRC_IDX_W-1:0] svc_src,
  output logic svc_high,
  // Per-source priority levels
  output logic spi_irq_priority,
  output logic timer2_irq_priority,
  output logic uart0_irq_priority,
  output logic timer1_irq_priority,
  output logic ext_irq1_priority,
  output logic timer0_irq_priority,
  output logic ext_irq0_priority
);
  import irq_prio_pkg::*;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // One wait cycle per access keeps read data registered.
  logic ack_ff;
  logic [REG_W-1:0] interrupt_priority_level_ff, nxt_level;
  wire req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack_ff;
  wire hit_prio = (avs_address == PRIO_OFS);
  wire hit_stat = (avs_address == STAT_OFS);
  // A write lands at the edge where waitrequest is low, the one edge the master counts.
  wire wr_prio = avs_write && hit_prio && avs_byteenable[0] && ack_ff;
  // Only bits 6..0 are stored; bit 7 is forced on read.
  assign nxt_level = wr_prio ? (avs_writedata[REG_W-1:0] & PRIO_WR_MASK) // R1 R9
                             : interrupt_priority_level_ff;
  wire [REG_W-1:0] level_view = interrupt_priority_level_ff | UNUSED_BIT_MASK; // R1
  prio_reg_if prio_bus ();
  assign prio_bus.level = interrupt_priority_level_ff;

  wire [DATA_W-1:0] stat_view = {{(DATA_W-REG_W){1'b0}}, svc_high, 4'h0, svc_src};
  wire [DATA_W-1:0] rd_mux = hit_prio ? {{(DATA_W-REG_W){1'b0}}, level_view} :
                             hit_stat ? stat_view : UNMAPPED_RD;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      interrupt_priority_level_ff <= PRIO_RESET; // R11
      ack_ff <= 1'b0;
      avs_readdata <= UNMAPPED_RD;
    end else begin
      interrupt_priority_level_ff <= nxt_level; // R9
      ack_ff <= req && !ack_ff;
      if (avs_read && !ack_ff) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  assign spi_irq_priority = interrupt_priority_level_ff[SPI_BIT]; // R2
  assign timer2_irq_priority = interrupt_priority_level_ff[T2_BIT]; // R3
  assign uart0_irq_priority = interrupt_priority_level_ff[U0_BIT]; // R4
  assign timer1_irq_priority = interrupt_priority_level_ff[T1_BIT]; // R5
  assign ext_irq1_priority = interrupt_priority_level_ff[X1_BIT]; // R6
  assign timer0_irq_priority = interrupt_priority_level_ff[T0_BIT]; // R7
  assign ext_irq0_priority = interrupt_priority_level_ff[X0_BIT]; // R8

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  irq_prio_arbiter u_irq_prio_arbiter (
    .mclk(mclk),
    .rst(rst),
    .prio(prio_bus.user),
    .irq_req(irq_req),
    .svc_done(svc_done),
    .svc_take(svc_take),
    .svc_src(svc_src),
    .svc_high(svc_high)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_top_bit_one: assert property (@(posedge mclk) disable iff (rst) // R1
    (avs_read && hit_prio && !ack_ff) |=> avs_readdata[REG_W-1])
    else $error("unused bit did not read as one");
  a_write_stores: assert property (@(posedge mclk) disable iff (rst) // R9
    wr_prio |=> (interrupt_priority_level_ff == ($past(avs_writedata[REG_W-1:0]) & PRIO_WR_MASK)))
    else $error("priority write not stored");
  // A one-cycle reset clears the register at the edge where rst is sampled high.
  a_hold_value: assert property (@(posedge mclk) disable iff (rst) // R9
    (!rst && !wr_prio) |=> $stable(interrupt_priority_level_ff))
    else $error("priority changed without write");
  a_reset_clear: assert property (@(posedge mclk) // R11
    rst |=> (interrupt_priority_level_ff == PRIO_RESET))
    else $error("reset did not clear priorities");
  a_spi_level: assert property (@(posedge mclk) disable iff (rst) // R2
    (wr_prio && avs_writedata[SPI_BIT]) |=> spi_irq_priority)
    else $error("spi priority not high");
  a_t2_level: assert property (@(posedge mclk) disable iff (rst) // R3
    (wr_prio && !avs_writedata[T2_BIT]) |=> !timer2_irq_priority)
    else $error("timer2 priority not low");
  a_u0_level: assert property (@(posedge mclk) disable iff (rst) // R4
    (wr_prio && avs_writedata[U0_BIT]) |=> uart0_irq_priority)
    else $error("uart0 priority not high");
  a_t1_level: assert property (@(posedge mclk) disable iff (rst) // R5
    (wr_prio && avs_writedata[T1_BIT]) |=> timer1_irq_priority)
    else $error("timer1 priority not high");
  a_x1_level: assert property (@(posedge mclk) disable iff (rst) // R6
    (wr_prio && avs_writedata[X1_BIT]) |=> ext_irq1_priority)
    else $error("ext1 priority not high");
  a_t0_level: assert property (@(posedge mclk) disable iff (rst) // R7
    (wr_prio && avs_writedata[T0_BIT]) |=> timer0_irq_priority)
    else $error("timer0 priority not high");
  a_x0_level: assert property (@(posedge mclk) disable iff (rst) // R8
    (wr_prio && avs_writedata[X0_BIT]) |=> ext_irq0_priority)
    else $error("ext0 priority not high");
  a_bus_answer: assert property (@(posedge mclk) disable iff (rst)
    (req && !ack_ff) |=> !avs_waitrequest)
    else $error("bus answer late");
  a_spi_low: assert property (@(posedge mclk) disable iff (rst) // R2
    (wr_prio && !avs_writedata[SPI_BIT]) |=> !spi_irq_priority)
    else $error("spi priority not low");
  a_t2_high: assert property (@(posedge mclk) disable iff (rst) // R3
    (wr_prio && avs_writedata[T2_BIT]) |=> timer2_irq_priority)
    else $error("timer2 priority not high");
  a_u0_low: assert property (@(posedge mclk) disable iff (rst) // R4
    (wr_prio && !avs_writedata[U0_BIT]) |=> !uart0_irq_priority)
    else $error("uart0 priority not low");
  a_t1_low: assert property (@(posedge mclk) disable iff (rst) // R5
    (wr_prio && !avs_writedata[T1_BIT]) |=> !timer1_irq_priority)
    else $error("timer1 priority not low");
  a_x1_low: assert property (@(posedge mclk) disable iff (rst) // R6
    (wr_prio && !avs_writedata[X1_BIT]) |=> !ext_irq1_priority)
    else $error("ext1 priority not low");
  a_t0_low: assert property (@(posedge mclk) disable iff (rst) // R7
    (wr_prio && !avs_writedata[T0_BIT]) |=> !timer0_irq_priority)
    else $error("timer0 priority not low");
  a_x0_low: assert property (@(posedge mclk) disable iff (rst) // R8
    (wr_prio && !avs_writedata[X0_BIT]) |=> !ext_irq0_priority)
    else $error("ext0 priority not low");

  // ----------------------------------------
  // Bus checks
  // ----------------------------------------
  a_write_at_ack: assert property (@(posedge mclk) disable iff (rst) // R9
    (!rst && avs_write && avs_waitrequest) |=> $stable(interrupt_priority_level_ff))
    else $error("write took effect while waiting");
  a_wait_first: assert property (@(posedge mclk) disable iff (rst)
    (req && !ack_ff) |-> avs_waitrequest)
    else $error("bus answered without a wait cycle");
  a_read_stands: assert property (@(posedge mclk) disable iff (rst)
    (!rst && !(avs_read && !ack_ff)) |=> $stable(avs_readdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (@(posedge mclk) disable iff (rst)
    (avs_read && !hit_prio && !hit_stat && !ack_ff) |=> (avs_readdata == UNMAPPED_RD))
    else $error("unmapped read not zero");
  a_reset_readdata: assert property (@(posedge mclk)
    rst |=> (avs_readdata == UNMAPPED_RD))
    else $error("reset did not clear read data");
  c_write: cover property (@(posedge mclk) disable iff (rst) wr_prio);
  c_read: cover property (@(posedge mclk) disable iff (rst) avs_read && hit_prio && ack_ff);
  c_high_take: cover property (@(posedge mclk) disable iff (rst) svc_take && svc_high);
endmodule
`default_nettype wire

// File: hw/irq_prio_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module irq_prio_arbiter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Priority levels
  prio_reg_if.user prio,
  // Core interface
  input wire logic [irq_prio_pkg::NSRC-1:0] irq_req,
  input wire logic svc_done,
  output logic svc_take,
  output logic [irq_prio_pkg::SRC_IDX_W-1:0] svc_src,
  output logic svc_high
);
  import irq_prio_pkg::*;

  // ----------------------------------------
  // Selection
  // ----------------------------------------
  // Lower index wins within a level, matching the usual polling order.
  wire [NSRC-1:0] hi_req = irq_req & prio.level[NSRC-1:0];
  wire [NSRC-1:0] lo_req = irq_req & ~prio.level[NSRC-1:0];
  logic [SRC_IDX_W-1:0] hi_idx, lo_idx;
  always_comb begin
    hi_idx = NO_SRC;
    lo_idx = NO_SRC;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (hi_req[i]) begin
        hi_idx = SRC_IDX_W'(i);
      end
      if (lo_req[i]) begin
        lo_idx = SRC_IDX_W'(i);
      end
    end
  end
  wire any_hi = |hi_req;
  wire any_lo = |lo_req;

  svc_state_t state_ff, nxt_state;
  // A nested low service is remembered so it resumes after the high one.
  logic nested_ff, nxt_nested;
  wire take_hi = any_hi && (state_ff != ST_HIGH); // R10
  wire take_lo = any_lo && !any_hi && (state_ff == ST_IDLE); // R10
  assign svc_take = take_hi || take_lo;

  always_comb begin
    nxt_state = state_ff;
    nxt_nested = nested_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take_hi) begin
          nxt_state = ST_HIGH;
        end else if (take_lo) begin
          nxt_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (take_hi) begin
          nxt_state = ST_HIGH;
          nxt_nested = 1'b1;
        end else if (svc_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_HIGH: begin
        if (svc_done) begin
          nxt_state = nested_ff ? ST_LOW : ST_IDLE;
          nxt_nested = 1'b0;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_nested = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      nested_ff <= 1'b0;
      svc_src <= NO_SRC;
      svc_high <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      nested_ff <= nxt_nested;
      if (svc_take) begin
        svc_src <= take_hi ? hi_idx : lo_idx;
        svc_high <= take_hi;
      end
    end
  end

  a_no_low_preempt: assert property (@(posedge mclk) disable iff (rst) // R10
    (state_ff == ST_HIGH && !svc_done) |=> (state_ff == ST_HIGH && $stable(svc_src)))
    else $error("low request preempted high service");
  a_high_preempts_low: assert property (@(posedge mclk) disable iff (rst) // R10
    (state_ff == ST_LOW && any_hi) |=> (state_ff == ST_HIGH && svc_high))
    else $error("high request did not preempt low service");
  c_nested: cover property (@(posedge mclk) disable iff (rst)
    state_ff == ST_LOW ##1 state_ff == ST_HIGH);
endmodule
`default_nettype wire

// File: hw/irq_prio_pkg.sv
package irq_prio_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int NSRC = 7;
  localparam logic [ADDR_W-1:0] PRIO_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
  localparam logic [REG_W-1:0] PRIO_RESET = 8'h00;
  localparam logic [REG_W-1:0] UNUSED_BIT_MASK = 8'h80;
  localparam logic [REG_W-1:0] PRIO_WR_MASK = 8'h7F;
  localparam int SPI_BIT = 6;
  localparam int T2_BIT = 5;
  localparam int U0_BIT = 4;
  localparam int T1_BIT = 3;
  localparam int X1_BIT = 2;
  localparam int T0_BIT = 1;
  localparam int X0_BIT = 0;
  localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;
  localparam int SRC_IDX_W = 3;
  localparam logic [SRC_IDX_W-1:0] NO_SRC = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b100
  } svc_state_t;
endpackage

// File: hw/prio_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface prio_reg_if;
  import irq_prio_pkg::*;
  logic [REG_W-1:0] level;
  modport owner (output level);
  modport user (input level);
endinterface
`default_nettype wire

// File: testbench/interrupt_priority_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_select_bench;
  import irq_prio_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  logic [NSRC-1:0] irq_req = '0;
  logic svc_done = 1'b0;
  logic svc_take;
  logic [SRC_IDX_W-1:0] svc_src;
  logic svc_high;
  wire [6:0] prio_out;
  logic [DATA_W-1:0] rd;
  int failures = 0;
  int checks = 0;
  interrupt_priority_select u_interrupt_priority_select (.mclk(mclk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq_req(irq_req),
    .svc_done(svc_done), .svc_take(svc_take), .svc_src(svc_src), .svc_high(svc_high),
    .spi_irq_priority(prio_out[6]), .timer2_irq_priority(prio_out[5]),
    .uart0_irq_priority(prio_out[4]), .timer1_irq_priority(prio_out[3]),
    .ext_irq1_priority(prio_out[2]), .timer0_irq_priority(prio_out[1]),
    .ext_irq0_priority(prio_out[0]));
  always #50 mclk = ~mclk;
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  // Sampling at the rising edge sees what the design acts on there; the watchdog ends a hang.
  task automatic bus_wait();
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
  endtask
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask
  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Waits for an accepted request, then drops the taken source's request line.
  task automatic take(input int src, input logic hi);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (svc_take !== 1'b1 && n < 20);
    check("take", 32'h1, {31'h0, svc_take});
    @(posedge mclk);
    irq_req[src] <= 1'b0;
    @(negedge mclk);
    check("svc_src", src, {29'h0, svc_src});
    check("svc_high", {31'h0, hi}, {31'h0, svc_high});
  endtask
  task automatic done_pulse();
    @(posedge mclk);
    svc_done <= 1'b1;
    @(posedge mclk);
    svc_done <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #200000;
    failures++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    bus_read(PRIO_OFS, rd);
    check("reset value", 32'h80, rd);
    check("reset outputs", 32'h0, {25'h0, prio_out});
    check("reset service", 32'h7, {28'h0, svc_high, svc_src});
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      bus_write(PRIO_OFS, 32'h1 << i);
      bus_read(PRIO_OFS, rd);
      check("single bit", 32'h80 | (32'h1 << i), rd);
      check("priority pins", 32'h1 << i, {25'h0, prio_out});
    end
    $display("test bits done");
    bus_write(PRIO_OFS, 32'hFF);
    bus_read(PRIO_OFS, rd);
    check("all bits", 32'hFF, rd);
    check("all pins", 32'h7F, {25'h0, prio_out});
    bus_write(PRIO_OFS, 32'h2A);
    bus_read(PRIO_OFS, rd);
    check("bit7 write ignored", 32'hAA, rd);
    avs_byteenable <= 4'hE;
    bus_write(PRIO_OFS, 32'h55);
    avs_byteenable <= 4'hF;
    bus_read(PRIO_OFS, rd);
    check("lane refused", 32'hAA, rd);
    bus_write(4'h8, 32'hFF);
    bus_read(4'h8, rd);
    check("unmapped", UNMAPPED_RD, rd);
    repeat (10) @(posedge mclk);
    bus_read(PRIO_OFS, rd);
    check("held value", 32'hAA, rd);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    bus_read(PRIO_OFS, rd);
    check("second reset", 32'h80, rd);
    check("second reset pins", 32'h0, {25'h0, prio_out});
    $display("test register done");
    // Only the SPI source is high; ext0 is low and competes with it.
    bus_write(PRIO_OFS, 32'h40);
    @(posedge mclk);
    irq_req <= 7'h41;
    take(6, 1'b1);
    bus_read(STAT_OFS, rd);
    check("status", 32'h86, rd);
    repeat (4) begin
      @(negedge mclk);
      check("low under high", 32'h0, {31'h0, svc_take});
    end
    done_pulse();
    take(0, 1'b0);
    @(posedge mclk);
    irq_req <= 7'h40;
    take(6, 1'b1);
    done_pulse();
    irq_req <= 7'h01;
    repeat (3) begin
      @(negedge mclk);
      check("low resumed", 32'h0, {31'h0, svc_take});
    end
    done_pulse();
    take(0, 1'b0);
    done_pulse();
    $display("test preemption done");
    summarize();
  end
endmodule
`default_nettype wire
